// file: rtl/crrs_alu.sv
// rotate-through-carry and literal-minus-accumulator arithmetic
`timescale 1ns/1ps
module crrs_alu (
	crrs_alu_if.alu io
);
	localparam int M = crrs_pkg::MSB;
	localparam int N = crrs_pkg::NIB_W;

	// ----------------------------------------------------------------
	// candidate results
	// ----------------------------------------------------------------
	wire [M:0] rol_res = {io.operand[M-1:0], io.carry_in};
	wire [M:0] ror_res = {io.carry_in, io.operand[M:1]};
	wire [M:0] sub_res = io.literal - io.acc;
	// carry is "no borrow"; digit carry likewise on the low nibble
	wire sub_c = io.literal >= io.acc;
	wire sub_dc = io.literal[N-1:0] >= io.acc[N-1:0];

	wire is_rol = io.op == crrs_pkg::OP_ROTATE_LEFT_THROUGH_CARRY;
	wire is_ror = io.op == crrs_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY;

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	assign io.result = is_rol ? rol_res : (is_ror ? ror_res : sub_res);
	assign io.carry_out = is_rol ? io.operand[M] :
		(is_ror ? io.operand[crrs_pkg::LSB] : sub_c);
	assign io.dc_out = sub_dc;
	assign io.zero_out = io.result == crrs_pkg::ZERO_BYTE;
endmodule // crrs_alu

// file: rtl/crrs_alu_if.sv
// datapath signals between the core sequencer and its arithmetic unit
`timescale 1ns/1ps
interface crrs_alu_if;
	crrs_pkg::crrs_op_e op;
	logic [crrs_pkg::DATA_W-1:0] operand;
	logic [crrs_pkg::DATA_W-1:0] literal;
	logic [crrs_pkg::DATA_W-1:0] acc;
	logic carry_in;
	logic [crrs_pkg::DATA_W-1:0] result;
	logic carry_out;
	logic dc_out;
	logic zero_out;

	modport core (output op, operand, literal, acc, carry_in,
		input result, carry_out, dc_out, zero_out);
	modport alu (input op, operand, literal, acc, carry_in,
		output result, carry_out, dc_out, zero_out);
endinterface // crrs_alu_if

// file: rtl/crrs_core.sv
// sequencer for returns, rotates, sleep and literal subtraction
`timescale 1ns/1ps
// Functional notes
// - interrupt return loads pc from stack, pops, sets interrupt enable; two cycles.
// - literal return writes literal to accumulator, loads pc, pops; two cycles.
// - plain return loads pc from stack and pops; no flags, two cycles.
// - rotate left: bit n to n+1, old carry to bit 0, carry from bit 7.
// - destination bit 0 writes accumulator, 1 writes the addressed file register.
// - rotate right: bit n to n-1, old carry to bit 7, carry from bit 0.
// - sleep stops the oscillator and updates only the power-down flag.
// - during sleep an external interrupt restarts execution.
// - literal minus accumulator into accumulator, updating carry, digit carry, zero.
module crrs_core #(
	parameter int PC_W = crrs_pkg::PC_W_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// instruction issue
	input wire logic op_valid,
	input wire crrs_pkg::crrs_op_e op_code,
	input wire logic [crrs_pkg::DATA_W-1:0] op_literal,
	input wire logic [crrs_pkg::FADDR_W-1:0] op_file_addr,
	input wire logic op_dest,
	input wire logic [crrs_pkg::DATA_W-1:0] file_rdata,
	// return stack
	input wire logic [PC_W-1:0] stack_top,
	output logic stack_pop_q,
	// wake source
	input wire logic ext_irq,
	// architectural state
	output logic [PC_W-1:0] pc_q,
	output logic [crrs_pkg::DATA_W-1:0] acc_q,
	output logic carry_q,
	output logic digit_carry_flag_q,
	output logic zero_q,
	output logic global_interrupt_enable_q,
	output logic power_down_flag_q,
	// file register write port
	output logic file_we_q,
	output logic [crrs_pkg::FADDR_W-1:0] file_addr_q,
	output logic [crrs_pkg::DATA_W-1:0] file_wdata_q,
	// status
	output logic osc_run_q,
	output logic busy_q
);
	crrs_pkg::crrs_state_e state_q, state_d;
	crrs_pkg::crrs_op_e ret_op_q;
	crrs_alu_if alu_bus ();

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic is_return(input crrs_pkg::crrs_op_e op);
		is_return = op == crrs_pkg::OP_RETURN_FROM_INTERRUPT ||
			op == crrs_pkg::OP_RETURN_WITH_LITERAL ||
			op == crrs_pkg::OP_RETURN;
	endfunction

	function automatic logic is_rotate(input crrs_pkg::crrs_op_e op);
		is_rotate = op == crrs_pkg::OP_ROTATE_LEFT_THROUGH_CARRY ||
			op == crrs_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY;
	endfunction

	// instructions are only taken while running; busy cycles drop them
	wire accept = op_valid && state_q == crrs_pkg::ST_RUN;
	wire acc_ret = accept && is_return(op_code);
	wire acc_rot = accept && is_rotate(op_code);
	wire acc_sub = accept &&
		op_code == crrs_pkg::OP_LITERAL_MINUS_ACCUMULATOR;
	wire acc_lit = accept && op_code == crrs_pkg::OP_RETURN_WITH_LITERAL;
	wire acc_sleep = accept && op_code == crrs_pkg::OP_SLEEP;
	wire rot_to_acc = acc_rot && op_dest == crrs_pkg::DEST_ACC;
	wire rot_to_file = acc_rot && op_dest == crrs_pkg::DEST_FILE;
	wire in_ret = state_q == crrs_pkg::ST_RET;
	wire wake = state_q == crrs_pkg::ST_SLEEP && ext_irq;

	// ----------------------------------------------------------------
	// arithmetic
	// ----------------------------------------------------------------
	assign alu_bus.op = op_code;
	assign alu_bus.operand = file_rdata;
	assign alu_bus.literal = op_literal;
	assign alu_bus.acc = acc_q;
	assign alu_bus.carry_in = carry_q;

	crrs_alu u_alu (
		.io(alu_bus)
	);

	wire acc_load = rot_to_acc || acc_sub || acc_lit;
	wire [crrs_pkg::DATA_W-1:0] acc_d = acc_lit ? op_literal :
		alu_bus.result;
	wire flags_load = acc_rot || acc_sub;

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
		crrs_pkg::ST_RUN: begin
			if (acc_ret)
				state_d = crrs_pkg::ST_RET;
			else if (acc_sleep)
				state_d = crrs_pkg::ST_SLEEP;
		end
		crrs_pkg::ST_RET: state_d = crrs_pkg::ST_RUN;
		crrs_pkg::ST_SLEEP: begin
			if (wake)
				state_d = crrs_pkg::ST_RUN;
		end
		default: state_d = crrs_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= crrs_pkg::ST_RUN;
			ret_op_q <= crrs_pkg::OP_NONE;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q <= state_d != crrs_pkg::ST_RUN;
			if (acc_ret)
				ret_op_q <= op_code;
		end
	end

	// ----------------------------------------------------------------
	// return: second cycle loads pc and pops
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= '0;
			stack_pop_q <= 1'b0;
			global_interrupt_enable_q <= 1'b0;
		end else begin
			stack_pop_q <= in_ret;
			if (in_ret)
				pc_q <= stack_top;
			if (in_ret && ret_op_q == crrs_pkg::OP_RETURN_FROM_INTERRUPT)
				global_interrupt_enable_q <= crrs_pkg::GIE_ON;
		end
	end

	// ----------------------------------------------------------------
	// accumulator, flags and file write
	// ----------------------------------------------------------------
	// flags only move on rotate and subtract, so returns keep them
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= crrs_pkg::ACC_RST;
			carry_q <= 1'b0;
			zero_q <= 1'b0;
			digit_carry_flag_q <= 1'b0;
		end else begin
			if (acc_load)
				acc_q <= acc_d;
			if (flags_load) begin
				carry_q <= alu_bus.carry_out;
				zero_q <= alu_bus.zero_out;
			end
			if (acc_sub)
				digit_carry_flag_q <= alu_bus.dc_out;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			file_we_q <= 1'b0;
			file_addr_q <= '0;
			file_wdata_q <= crrs_pkg::ZERO_BYTE;
		end else begin
			file_we_q <= rot_to_file;
			if (rot_to_file) begin
				file_addr_q <= op_file_addr;
				file_wdata_q <= alu_bus.result;
			end
		end
	end

	// ----------------------------------------------------------------
	// sleep and wake
	// ----------------------------------------------------------------
	// the flag stays set after wake so software can see it slept
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_run_q <= 1'b1;
			power_down_flag_q <= 1'b0;
		end else begin
			if (acc_sleep) begin
				osc_run_q <= 1'b0;
				power_down_flag_q <= crrs_pkg::PD_ASLEEP;
			end else if (wake)
				osc_run_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence ret_issue;
		acc_ret;
	endsequence
	sequence ret_done;
		busy_q && !stack_pop_q ##1 stack_pop_q && !busy_q &&
			pc_q == $past(stack_top);
	endsequence

	a_ret_two_cycle: assert property (ret_issue |=> ret_done)
		else $error("return did not load pc and pop in two cycles");
	a_rfi_sets_gie: assert property (accept &&
		op_code == crrs_pkg::OP_RETURN_FROM_INTERRUPT |=> ##1
		global_interrupt_enable_q)
		else $error("interrupt return left interrupts disabled");
	a_ret_keeps_flags: assert property (ret_issue |-> ##2
		carry_q == $past(carry_q, 2) && zero_q == $past(zero_q, 2))
		else $error("return changed a flag");
	a_return_with_literal_op_acc: assert property (acc_lit |=>
		acc_q == $past(op_literal))
		else $error("literal return did not load accumulator");
	a_rol_acc: assert property (rot_to_acc &&
		op_code == crrs_pkg::OP_ROTATE_LEFT_THROUGH_CARRY |=>
		acc_q == {$past(file_rdata[6:0]), $past(carry_q)} &&
		carry_q == $past(file_rdata[7]))
		else $error("rotate left result wrong");
	a_ror_file: assert property (rot_to_file &&
		op_code == crrs_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY |=>
		file_we_q && acc_q == $past(acc_q) &&
		file_wdata_q == {$past(carry_q), $past(file_rdata[7:1])} &&
		carry_q == $past(file_rdata[0]))
		else $error("rotate right to file wrong");
	a_sleep_stops: assert property (acc_sleep |=>
		!osc_run_q && power_down_flag_q && busy_q &&
		carry_q == $past(carry_q))
		else $error("sleep did not stop oscillator");
	a_wake_up: assert property (wake |=> osc_run_q && !busy_q)
		else $error("external interrupt did not wake core");
	// zero is judged from the operands, not from the stored result
	a_sub_value: assert property (acc_sub |=>
		acc_q == 8'($past(op_literal) - $past(acc_q)) &&
		carry_q == ($past(op_literal) >= $past(acc_q)) &&
		digit_carry_flag_q ==
		($past(op_literal[3:0]) >= $past(acc_q[3:0])) &&
		zero_q == ($past(op_literal) == $past(acc_q)))
		else $error("literal subtraction wrong");
endmodule // crrs_core

// file: rtl/crrs_pkg.sv
// shared constants and types for the return, rotate and subtract core
package crrs_pkg;
	// ----------------------------------------------------------------
	// widths and field positions
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int MSB = DATA_W - 1;
	localparam int LSB = 0;
	localparam int PC_W_DEF = 11;
	localparam int FADDR_W = 8;

	// ----------------------------------------------------------------
	// reset values and destination codes
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	localparam logic GIE_ON = 1'b1;
	localparam logic PD_ASLEEP = 1'b1;

	// ----------------------------------------------------------------
	// operations and core states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_RETURN_FROM_INTERRUPT,
		OP_RETURN_WITH_LITERAL,
		OP_RETURN,
		OP_ROTATE_LEFT_THROUGH_CARRY,
		OP_ROTATE_RIGHT_THROUGH_CARRY,
		OP_SLEEP,
		OP_LITERAL_MINUS_ACCUMULATOR
	} crrs_op_e;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_RET,
		ST_SLEEP
	} crrs_state_e;
endpackage

// file: verification/crrs_stack_model.sv
// return stack model facing the core
`timescale 1ns/1ps
module crrs_stack_model #(
	parameter int PC_W = crrs_pkg::PC_W_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// bench side
	input wire logic push,
	input wire logic [PC_W-1:0] push_val,
	// core side
	input wire logic stack_pop_q,
	output logic [PC_W-1:0] stack_top
);
	logic [PC_W-1:0] stk_q [0:7];
	logic [3:0] sp_q;
	logic [PC_W-1:0] last_q;
	// empty stack shows the inverse of the last entry, never a stale copy
	assign stack_top = (sp_q != 4'h0) ? stk_q[sp_q-4'h1] : ~last_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= 4'h0;
			last_q <= '0;
		end else if (stack_pop_q && sp_q != 4'h0) begin
			sp_q <= sp_q - 4'h1;
			last_q <= stack_top;
		end else if (push) begin
			stk_q[sp_q[2:0]] <= push_val;
			sp_q <= sp_q + 4'h1;
		end
	end
endmodule // crrs_stack_model

// file: verification/testbench.sv
// self-checking bench for the return, rotate and subtract core
`timescale 1ns/1ps
module testbench;
	localparam int PW = crrs_pkg::PC_W_DEF;
	localparam crrs_pkg::crrs_op_e SUB = crrs_pkg::OP_LITERAL_MINUS_ACCUMULATOR;
	localparam crrs_pkg::crrs_op_e RL = crrs_pkg::OP_ROTATE_LEFT_THROUGH_CARRY;
	localparam crrs_pkg::crrs_op_e RR = crrs_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY;
	typedef struct packed {
		crrs_pkg::crrs_op_e op;
		logic [7:0] k;
		logic [7:0] f;
		logic d;
		logic [7:0] r;
		logic c;
		logic z;
		logic dc;
	} crrs_row_s;
	logic sys_clk, rst_n, op_valid, op_dest, ext_irq, push, stack_pop_q;
	crrs_pkg::crrs_op_e op_code;
	logic [7:0] op_literal, op_file_addr, file_rdata, acc_q;
	logic [7:0] file_addr_q, file_wdata_q;
	logic [PW-1:0] stack_top, pc_q, push_val;
	logic carry_q, digit_carry_flag_q, zero_q, global_interrupt_enable_q;
	logic power_down_flag_q, file_we_q, osc_run_q, busy_q;
	logic [2:0] fl;
	int err_count = 0;
	int check_count = 0;
	// rows chain: each starts from the state the previous one left
	crrs_row_s rows [0:10] = '{
		'{SUB, 8'h02, 8'h00, 1'b0, 8'h02, 1'b1, 1'b0, 1'b1},
		'{SUB, 8'h02, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
		'{SUB, 8'h03, 8'h00, 1'b0, 8'h03, 1'b1, 1'b0, 1'b1},
		'{SUB, 8'h02, 8'h00, 1'b0, 8'hff, 1'b0, 1'b0, 1'b0},
		'{SUB, 8'h10, 8'h00, 1'b0, 8'h11, 1'b0, 1'b0, 1'b0},
		'{RL, 8'h21, 8'he6, 1'b1, 8'hcc, 1'b1, 1'b0, 1'b0},
		'{RR, 8'h22, 8'h95, 1'b0, 8'hca, 1'b1, 1'b0, 1'b0},
		'{RL, 8'hff, 8'h00, 1'b1, 8'h01, 1'b0, 1'b0, 1'b0},
		'{RR, 8'h00, 8'h01, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0},
		'{RR, 8'h23, 8'h00, 1'b0, 8'h80, 1'b0, 1'b0, 1'b0},
		'{RL, 8'h24, 8'h80, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0}};

	crrs_core u_dut (.sys_clk, .rst_n, .op_valid, .op_code, .op_literal,
		.op_file_addr, .op_dest, .file_rdata, .stack_top, .stack_pop_q,
		.ext_irq, .pc_q, .acc_q, .carry_q, .digit_carry_flag_q, .zero_q,
		.global_interrupt_enable_q, .power_down_flag_q, .file_we_q,
		.file_addr_q, .file_wdata_q, .osc_run_q, .busy_q);
	crrs_stack_model u_stack (.sys_clk, .rst_n, .push, .push_val,
		.stack_pop_q, .stack_top);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ------
	// tasks
	// ------
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic do_ret(input crrs_pkg::crrs_op_e op, input logic [7:0] k,
		input logic [PW-1:0] pc, input logic global_interrupt_enable);
		fl = {carry_q, digit_carry_flag_q, zero_q};
		op_valid = 1'b1;
		op_code = op;
		op_literal = k;
		tick();
		op_valid = 1'b0;
		chk({busy_q, stack_pop_q}, 2'b10);
		if (op == crrs_pkg::OP_RETURN_WITH_LITERAL) chk(acc_q, k);
		tick();
		chk({pc_q, stack_pop_q, busy_q, global_interrupt_enable_q},
			{pc, 2'b10, global_interrupt_enable});
		chk({carry_q, digit_carry_flag_q, zero_q}, fl);
		$display("return test done");
	endtask
	task automatic reset_chk();
		chk({pc_q, acc_q, carry_q, digit_carry_flag_q, zero_q},
			22'h000000);
		chk({global_interrupt_enable_q, power_down_flag_q, osc_run_q,
			busy_q, file_we_q, stack_pop_q}, 6'b001000);
		$display("reset test done");
	endtask

	// ------
	// main sequence
	// ------
	initial begin
		rst_n = 1'b0;
		op_valid = 1'b0;
		op_code = crrs_pkg::OP_NONE;
		op_literal = 8'h00;
		op_file_addr = 8'h00;
		op_dest = 1'b0;
		file_rdata = 8'h00;
		ext_irq = 1'b0;
		push = 1'b0;
		push_val = '0;
		repeat (16) tick();
		rst_n = 1'b1;
		reset_chk();
		for (int i = 0; i < 11; i++) begin
			op_valid = 1'b1;
			op_code = rows[i].op;
			op_literal = rows[i].k;
			op_file_addr = rows[i].k;
			file_rdata = rows[i].f;
			op_dest = rows[i].d;
			tick();
			if (rows[i].d) begin
				chk({file_we_q, file_addr_q, file_wdata_q},
					{1'b1, rows[i].k, rows[i].r});
			end else begin
				chk({file_we_q, acc_q}, {1'b0, rows[i].r});
			end
			chk({carry_q, zero_q}, {rows[i].c, rows[i].z});
			if (rows[i].op == SUB) chk(digit_carry_flag_q, rows[i].dc);
		end
		op_valid = 1'b0;
		$display("row test done");
		push = 1'b1;
		push_val = 11'h7ff;
		tick();
		push_val = 11'h123;
		tick();
		push_val = 11'h456;
		tick();
		push = 1'b0;
		do_ret(crrs_pkg::OP_RETURN_WITH_LITERAL, 8'h5a, 11'h456, 1'b0);
		do_ret(crrs_pkg::OP_RETURN, 8'h00, 11'h123, 1'b0);
		do_ret(crrs_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 11'h7ff, 1'b1);
		fl = {carry_q, digit_carry_flag_q, zero_q};
		op_valid = 1'b1;
		op_code = crrs_pkg::OP_SLEEP;
		tick();
		// a subtract offered while asleep must be dropped
		op_code = SUB;
		op_literal = 8'h77;
		chk({osc_run_q, power_down_flag_q, busy_q}, 3'b011);
		repeat (5) tick();
		op_valid = 1'b0;
		op_code = crrs_pkg::OP_NONE;
		chk({osc_run_q, busy_q, carry_q, digit_carry_flag_q, zero_q},
			{2'b01, fl});
		ext_irq = 1'b1;
		tick();
		ext_irq = 1'b0;
		chk({osc_run_q, busy_q}, 2'b10);
		op_valid = 1'b1;
		tick();
		op_valid = 1'b0;
		chk({power_down_flag_q, acc_q, carry_q, digit_carry_flag_q, zero_q},
			{1'b1, 8'h5a, fl});
		$display("sleep test done");
		rst_n = 1'b0;
		tick();
		reset_chk();
		final_report();
	end

	initial begin
		#(50 * 1000);
		err_count++;
		final_report();
	end
endmodule // testbench
